// *** src/asq_evt.sv ***
// hop event selector: line synchronisers and edge qualification
`timescale 1ns/1ps
`default_nettype none
module asq_evt
	import asq_pkg::*;
#(
	parameter int NLINES = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic frame_begin_i,
	input wire logic [NLINES-1:0] line_i,
	input wire logic [ASQ_SRC_W-1:0] src_i,
	input wire logic [ASQ_EDGE_W-1:0] edge_i,
	output logic hit_o
);
	logic [NLINES-1:0] sync1_r;
	logic [NLINES-1:0] sync2_r;
	logic [NLINES:0] lvl;
	logic [NLINES:0] prev_r;
	logic [7:0] lvl8;
	logic [7:0] prev8;
	logic cur;
	logic prv;

	genvar k;
	generate
		for (k = 0; k < NLINES; k++) begin : g_sync
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					sync1_r[k] <= 1'b0;
					sync2_r[k] <= 1'b0;
				end else begin
					sync1_r[k] <= line_i[k];
					sync2_r[k] <= sync1_r[k];
				end
			end
		end
	endgenerate

	// frame begin comes from logic on this clock, so it skips the synchroniser
	assign lvl = {sync2_r, frame_begin_i};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_r <= '0;
		end else begin
			prev_r <= lvl;
		end
	end

	assign lvl8 = 8'(lvl);
	assign prev8 = 8'(prev_r);
	assign cur = lvl8[src_i];
	assign prv = prev8[src_i];

	always_comb begin
		case (edge_i)
			EDGE_RISING: hit_o = cur & ~prv;
			EDGE_FALLING: hit_o = ~cur & prv;
			EDGE_ANY: hit_o = cur ^ prv;
			EDGE_HIGH: hit_o = cur;
			default: hit_o = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// *** src/asq_pkg.sv ***
// constants, register map and field layout of the acquisition set sequencer
package asq_pkg;
	localparam int unsigned ASQ_MAX_SETS = 8;
	localparam int unsigned ASQ_IDX_W = 3;
	localparam int unsigned ASQ_NFEAT = 2;
	localparam int unsigned ASQ_SRC_W = 3;
	localparam int unsigned ASQ_EDGE_W = 2;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_FSEL = 8'h04;
	localparam logic [7:0] OFF_FEN = 8'h08;
	localparam logic [7:0] OFF_SETSEL = 8'h0c;
	localparam logic [7:0] OFF_BRANCH = 8'h10;
	localparam logic [7:0] OFF_PATH = 8'h14;
	localparam logic [7:0] OFF_FIRST = 8'h18;
	localparam logic [7:0] OFF_CMD = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_EXPOSURE = 8'h24;
	localparam logic [7:0] OFF_GAIN = 8'h28;
	localparam logic [7:0] OFF_IMPLIED = 8'h2c;
	localparam logic [7:0] OFF_FIXED = 8'h30;
	localparam logic [7:0] OFF_AUTO = 8'h34;
	localparam logic [7:0] OFF_FREE = 8'h38;

	localparam int unsigned CTRL_SETUP_BIT = 0;
	localparam int unsigned CTRL_RUN_BIT = 1;
	localparam int unsigned PATH_SRC_LSB = 0;
	localparam int unsigned PATH_EDGE_LSB = 4;
	localparam int unsigned PATH_NEXT_LSB = 8;
	localparam int unsigned CMD_STORE_BIT = 0;
	localparam int unsigned CMD_RECALL_BIT = 1;
	localparam int unsigned CMD_ERASE_BIT = 2;
	localparam int unsigned STAT_SETUP_OK_BIT = 0;
	localparam int unsigned STAT_SET_OK_BIT = 1;
	localparam int unsigned STAT_LOCK_BIT = 2;
	localparam int unsigned STAT_RUN_BIT = 3;
	localparam int unsigned STAT_SETUP_BIT = 4;
	localparam int unsigned STAT_VALID_LSB = 8;
	localparam int unsigned STAT_CUR_LSB = 16;

	localparam logic FEAT_EXPOSURE = 1'b0;
	localparam logic FEAT_GAIN = 1'b1;

	localparam logic [ASQ_SRC_W-1:0] SRC_FRAME_BEGIN = 3'h0;
	localparam logic [ASQ_EDGE_W-1:0] EDGE_RISING = 2'h0;
	localparam logic [ASQ_EDGE_W-1:0] EDGE_FALLING = 2'h1;
	localparam logic [ASQ_EDGE_W-1:0] EDGE_ANY = 2'h2;
	localparam logic [ASQ_EDGE_W-1:0] EDGE_HIGH = 2'h3;

	localparam logic [31:0] FEAT_RST = 32'h0000_0000;
	localparam logic [ASQ_IDX_W-1:0] IDX_RST = 3'h0;

	typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_RUN} asq_phase_e;
endpackage

// *** src/asq_seq.sv ***
// acquisition set sequencer with apb register access
`timescale 1ns/1ps
`default_nettype none
module asq_seq
	import asq_pkg::*;
#(
	parameter int NSETS = 8,
	parameter int DW = 32,
	parameter int NLINES = 4
) (
	input wire logic CLOCK_I,
	input wire logic RESETN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic FRAME_BEGIN_I,
	input wire logic [NLINES-1:0] LINE_I,
	input wire logic STREAMING_I,
	output logic [DW-1:0] EXPOSURE_O,
	output logic [DW-1:0] GAIN_O,
	output logic [DW-1:0] IMPLIED_O,
	output logic [DW-1:0] FIXED_O,
	output logic AUTO_EXPOSURE_O,
	output logic [DW-1:0] FREE_O,
	output logic [ASQ_IDX_W-1:0] CURRENT_SET_O,
	output logic RUNNING_O,
	output logic SETUP_O
);
	generate
		if (NSETS < 2 || NSETS > ASQ_MAX_SETS) begin : g_bad_sets
			$error("NSETS out of range");
		end
		if (DW < 1 || DW > 32) begin : g_bad_dw
			$error("DW out of range");
		end
		if (NLINES < 1 || NLINES > 7) begin : g_bad_lines
			$error("NLINES out of range");
		end
	endgenerate

	localparam logic [3:0] NSETS_W = 4'(NSETS);
	localparam logic [3:0] NLINES_W = 4'(NLINES);

	asq_phase_e phase_r;
	logic [ASQ_NFEAT-1:0] dir_on_r;
	logic [ASQ_NFEAT-1:0] seq_mask_r;
	logic dep_r;
	logic fsel_r;
	logic [ASQ_IDX_W-1:0] set_sel_r;
	logic [ASQ_IDX_W-1:0] branch_r;
	logic [ASQ_IDX_W-1:0] first_r;
	logic [ASQ_IDX_W-1:0] cur_r;
	logic setup_ok_r;
	logic [DW-1:0] exp_r;
	logic [DW-1:0] gain_r;
	logic [DW-1:0] impl_r;
	logic [DW-1:0] fixed_r;
	logic [DW-1:0] free_r;
	logic auto_r;
	logic auto_out_r;
	logic [31:0] prdata_r;

	// per-set storage; one path per set, so no branch dimension
	logic [DW-1:0] mem_exp_r [NSETS];
	logic [DW-1:0] mem_gain_r [NSETS];
	logic [DW-1:0] mem_impl_r [NSETS];
	logic [DW-1:0] mem_fix_r [NSETS];
	logic [ASQ_NFEAT-1:0] mem_mask_r [NSETS];
	logic [NSETS-1:0] stored_r;
	logic [ASQ_SRC_W-1:0] path_src_r [NSETS];
	logic [ASQ_EDGE_W-1:0] path_edge_r [NSETS];
	logic [ASQ_IDX_W-1:0] path_next_r [NSETS];
	logic [NSETS-1:0] set_ok;
	logic [NSETS-1:0] link_ok;
	logic [7:0] ok8;

	// apb decode
	logic acc;
	logic wr;
	logic hit_ctrl, hit_fsel, hit_fen, hit_setsel, hit_branch, hit_path, hit_first;
	logic hit_cmd, hit_stat, hit_exp, hit_gain, hit_impl, hit_fix, hit_auto, hit_free;
	logic unmapped;
	assign acc = PSEL_I & PENABLE_I;
	assign wr = acc & PWRITE_I;
	assign hit_ctrl = PADDR_I == OFF_CTRL;
	assign hit_fsel = PADDR_I == OFF_FSEL;
	assign hit_fen = PADDR_I == OFF_FEN;
	assign hit_setsel = PADDR_I == OFF_SETSEL;
	assign hit_branch = PADDR_I == OFF_BRANCH;
	assign hit_path = PADDR_I == OFF_PATH;
	assign hit_first = PADDR_I == OFF_FIRST;
	assign hit_cmd = PADDR_I == OFF_CMD;
	assign hit_stat = PADDR_I == OFF_STATUS;
	assign hit_exp = PADDR_I == OFF_EXPOSURE;
	assign hit_gain = PADDR_I == OFF_GAIN;
	assign hit_impl = PADDR_I == OFF_IMPLIED;
	assign hit_fix = PADDR_I == OFF_FIXED;
	assign hit_auto = PADDR_I == OFF_AUTO;
	assign hit_free = PADDR_I == OFF_FREE;
	assign unmapped = ~(hit_ctrl | hit_fsel | hit_fen | hit_setsel | hit_branch | hit_path
		| hit_first | hit_cmd | hit_stat | hit_exp | hit_gain | hit_impl | hit_fix
		| hit_auto | hit_free);

	// write data fields
	logic [ASQ_IDX_W-1:0] w_idx;
	logic [ASQ_SRC_W-1:0] w_src;
	logic [ASQ_EDGE_W-1:0] w_edge;
	logic [ASQ_IDX_W-1:0] w_next;
	logic w_store, w_recall, w_erase;
	assign w_idx = PWDATA_I[ASQ_IDX_W-1:0];
	assign w_src = PWDATA_I[PATH_SRC_LSB +: ASQ_SRC_W];
	assign w_edge = PWDATA_I[PATH_EDGE_LSB +: ASQ_EDGE_W];
	assign w_next = PWDATA_I[PATH_NEXT_LSB +: ASQ_IDX_W];
	assign w_store = PWDATA_I[CMD_STORE_BIT];
	assign w_recall = PWDATA_I[CMD_RECALL_BIT];
	assign w_erase = PWDATA_I[CMD_ERASE_BIT];

	logic in_run, in_setup, in_idle, sel_ok, cfg_ok;
	assign in_run = phase_r == PH_RUN;
	assign in_setup = phase_r == PH_SETUP;
	assign in_idle = phase_r == PH_IDLE;
	assign sel_ok = set_ok[set_sel_r];

	// phase switching
	logic go_setup, go_exit, go_run, go_stop, bad_ctrl;
	always_comb begin
		go_setup = 1'b0;
		go_exit = 1'b0;
		go_run = 1'b0;
		go_stop = 1'b0;
		bad_ctrl = 1'b0;
		case (phase_r)
			PH_IDLE: begin
				if (PWDATA_I[CTRL_SETUP_BIT] && PWDATA_I[CTRL_RUN_BIT]) begin
					bad_ctrl = 1'b1;
				end else if (PWDATA_I[CTRL_SETUP_BIT]) begin
					go_setup = 1'b1;
				end else if (PWDATA_I[CTRL_RUN_BIT]) begin
					// start needs a valid configuration and a stopped stream
					go_run = setup_ok_r & cfg_ok & ~STREAMING_I;
					bad_ctrl = ~go_run;
				end
			end
			PH_SETUP: begin
				bad_ctrl = PWDATA_I[CTRL_RUN_BIT];
				go_exit = ~PWDATA_I[CTRL_SETUP_BIT] & ~PWDATA_I[CTRL_RUN_BIT];
			end
			PH_RUN: begin
				bad_ctrl = PWDATA_I[CTRL_SETUP_BIT];
				go_stop = ~PWDATA_I[CTRL_RUN_BIT] & ~PWDATA_I[CTRL_SETUP_BIT];
			end
			default: bad_ctrl = 1'b1;
		endcase
	end

	// refusals; a refused write changes nothing and answers with pslverr
	logic bad_fen, bad_sel, bad_branch, bad_path, bad_first, bad_cmd;
	logic bad_exp, bad_gain, bad_impl, bad_fix, wr_bad;
	assign bad_fen = ~in_idle;
	assign bad_sel = {1'b0, w_idx} >= NSETS_W;
	assign bad_branch = w_idx != '0;
	assign bad_path = ~in_setup | (branch_r != '0) | ({1'b0, w_src} > NLINES_W)
		| ({1'b0, w_next} >= NSETS_W);
	assign bad_first = ~in_setup | bad_sel;
	assign bad_cmd = w_erase ? in_run : w_store ? ~in_setup : w_recall & ~sel_ok;
	assign bad_exp = in_run & seq_mask_r[FEAT_EXPOSURE];
	assign bad_gain = in_run & seq_mask_r[FEAT_GAIN];
	assign bad_impl = in_run & dep_r;
	assign bad_fix = ~in_idle & dep_r;
	assign wr_bad = (hit_ctrl & bad_ctrl) | (hit_fen & bad_fen) | (hit_setsel & bad_sel)
		| (hit_branch & bad_branch) | (hit_path & bad_path) | (hit_first & bad_first)
		| (hit_cmd & bad_cmd) | hit_stat | (hit_exp & bad_exp) | (hit_gain & bad_gain)
		| (hit_impl & bad_impl) | (hit_fix & bad_fix);

	logic wr_ok, do_erase, do_store, do_recall, path_wr;
	assign wr_ok = wr & ~unmapped & ~wr_bad;
	assign do_erase = wr_ok & hit_cmd & w_erase;
	assign do_store = wr_ok & hit_cmd & ~w_erase & w_store;
	assign do_recall = wr_ok & hit_cmd & ~w_erase & ~w_store & w_recall;
	assign path_wr = wr_ok & hit_path;

	// hop event of the current set's path
	logic evt, hop;
	asq_evt #(.NLINES(NLINES)) u_evt (
		.clk_i(CLOCK_I),
		.rst_n_i(RESETN_I),
		.frame_begin_i(FRAME_BEGIN_I),
		.line_i(LINE_I),
		.src_i(path_src_r[cur_r]),
		.edge_i(path_edge_r[cur_r]),
		.hit_o(evt)
	);
	assign hop = in_run & STREAMING_I & evt;

	// loading a set into the active configuration
	logic load, start;
	logic [ASQ_IDX_W-1:0] load_idx;
	assign start = wr_ok & hit_ctrl & go_run;
	assign load = start | do_recall | hop;
	assign load_idx = start ? first_r : do_recall ? set_sel_r : path_next_r[cur_r];

	// per-set storage and validity
	genvar i;
	generate
		for (i = 0; i < NSETS; i++) begin : g_set
			always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
				if (!RESETN_I) begin
					stored_r[i] <= 1'b0;
					mem_exp_r[i] <= '0;
					mem_gain_r[i] <= '0;
					mem_impl_r[i] <= '0;
					mem_fix_r[i] <= '0;
					mem_mask_r[i] <= '0;
					path_src_r[i] <= SRC_FRAME_BEGIN;
					path_edge_r[i] <= EDGE_RISING;
					path_next_r[i] <= IDX_RST;
				end else if (do_erase) begin
					stored_r[i] <= 1'b0;
					path_src_r[i] <= SRC_FRAME_BEGIN;
					path_edge_r[i] <= EDGE_RISING;
					path_next_r[i] <= IDX_RST;
				end else begin
					if (do_store && set_sel_r == ASQ_IDX_W'(i)) begin
						stored_r[i] <= 1'b1;
						mem_exp_r[i] <= exp_r;
						mem_gain_r[i] <= gain_r;
						mem_impl_r[i] <= impl_r;
						mem_fix_r[i] <= fixed_r;
						mem_mask_r[i] <= seq_mask_r;
					end
					if (path_wr && set_sel_r == ASQ_IDX_W'(i)) begin
						path_src_r[i] <= w_src;
						path_edge_r[i] <= w_edge;
						path_next_r[i] <= w_next;
					end
				end
			end
			// validity follows the live fixed value, so a later store with a
			// changed fixed feature drops older sets without extra bookkeeping
			assign set_ok[i] = stored_r[i] & (mem_fix_r[i] == fixed_r)
				& (mem_mask_r[i] == seq_mask_r)
				& (~mem_mask_r[i][FEAT_EXPOSURE] | (mem_exp_r[i] != '0));
			assign link_ok[i] = ~set_ok[i] | set_ok[path_next_r[i]];
		end
	endgenerate

	assign ok8 = 8'(set_ok);
	assign cfg_ok = set_ok[first_r] & (&link_ok);

	// control and active configuration
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			phase_r <= PH_IDLE;
			setup_ok_r <= 1'b0;
			seq_mask_r <= '0;
			dep_r <= 1'b0;
			cur_r <= IDX_RST;
		end else begin
			if (wr_ok && hit_ctrl && go_setup) begin
				phase_r <= PH_SETUP;
				seq_mask_r <= dir_on_r;
				dep_r <= |dir_on_r;
				setup_ok_r <= 1'b0;
			end else if (wr_ok && hit_ctrl && go_exit) begin
				phase_r <= PH_IDLE;
				setup_ok_r <= cfg_ok;
			end else if (start) begin
				phase_r <= PH_RUN;
			end else if (wr_ok && hit_ctrl && go_stop) begin
				phase_r <= PH_IDLE;
			end else if (do_erase) begin
				setup_ok_r <= 1'b0;
			end
			if (load) begin
				cur_r <= load_idx;
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			exp_r <= DW'(FEAT_RST);
			gain_r <= DW'(FEAT_RST);
			impl_r <= DW'(FEAT_RST);
		end else if (load) begin
			// sequenced features, and the implied one when any is sequenced, follow the set; the rest keep their value
			if (seq_mask_r[FEAT_EXPOSURE]) exp_r <= mem_exp_r[load_idx];
			if (seq_mask_r[FEAT_GAIN]) gain_r <= mem_gain_r[load_idx];
			if (dep_r) impl_r <= mem_impl_r[load_idx];
		end else if (wr_ok) begin
			if (hit_exp) exp_r <= PWDATA_I[DW-1:0];
			if (hit_gain) gain_r <= PWDATA_I[DW-1:0];
			if (hit_impl) impl_r <= PWDATA_I[DW-1:0];
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			fixed_r <= DW'(FEAT_RST);
			free_r <= DW'(FEAT_RST);
			auto_r <= 1'b0;
			auto_out_r <= 1'b0;
		end else begin
			if (wr_ok && hit_fix) fixed_r <= PWDATA_I[DW-1:0];
			if (wr_ok && hit_free) free_r <= PWDATA_I[DW-1:0];
			if (wr_ok && hit_auto) auto_r <= PWDATA_I[0];
			// user choice is kept, the drive is forced to manual while running
			auto_out_r <= auto_r & ~in_run;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			dir_on_r <= '0;
			fsel_r <= FEAT_EXPOSURE;
			set_sel_r <= IDX_RST;
			branch_r <= IDX_RST;
			first_r <= IDX_RST;
		end else if (do_erase) begin
			first_r <= IDX_RST;
		end else if (wr_ok) begin
			if (hit_fsel) fsel_r <= PWDATA_I[0];
			if (hit_fen) dir_on_r[fsel_r] <= PWDATA_I[0];
			if (hit_setsel) set_sel_r <= w_idx;
			if (hit_branch) branch_r <= w_idx;
			if (hit_first) first_r <= w_idx;
		end
	end

	// read side
	logic [31:0] stat_w;
	logic [31:0] path_rd;
	logic [31:0] rd_mux;
	always_comb begin
		stat_w = '0;
		stat_w[STAT_SETUP_OK_BIT] = setup_ok_r;
		stat_w[STAT_SET_OK_BIT] = sel_ok;
		stat_w[STAT_LOCK_BIT] = dep_r;
		stat_w[STAT_RUN_BIT] = in_run;
		stat_w[STAT_SETUP_BIT] = in_setup;
		stat_w[STAT_VALID_LSB +: 8] = ok8;
		stat_w[STAT_CUR_LSB +: ASQ_IDX_W] = cur_r;
	end
	always_comb begin
		path_rd = '0;
		path_rd[PATH_SRC_LSB +: ASQ_SRC_W] = path_src_r[set_sel_r];
		path_rd[PATH_EDGE_LSB +: ASQ_EDGE_W] = path_edge_r[set_sel_r];
		path_rd[PATH_NEXT_LSB +: ASQ_IDX_W] = path_next_r[set_sel_r];
	end
	assign rd_mux = hit_ctrl ? 32'({in_run, in_setup}) :
		hit_fsel ? 32'(fsel_r) :
		hit_fen ? 32'(dir_on_r[fsel_r]) :
		hit_setsel ? 32'(set_sel_r) :
		hit_branch ? 32'(branch_r) :
		hit_path ? path_rd :
		hit_first ? 32'(first_r) :
		hit_stat ? stat_w :
		hit_exp ? 32'(exp_r) :
		hit_gain ? 32'(gain_r) :
		hit_impl ? 32'(impl_r) :
		hit_fix ? 32'(fixed_r) :
		hit_auto ? 32'(auto_r) :
		hit_free ? 32'(free_r) : 32'h0000_0000;

	// read data sampled in the setup cycle so the port comes from a flop
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			prdata_r <= 32'h0000_0000;
		end else if (PSEL_I && !PENABLE_I) begin
			prdata_r <= PWRITE_I ? 32'h0000_0000 : rd_mux;
		end
	end

	assign PRDATA_O = prdata_r;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = acc & (unmapped | (PWRITE_I & wr_bad));
	assign EXPOSURE_O = exp_r;
	assign GAIN_O = gain_r;
	assign IMPLIED_O = impl_r;
	assign FIXED_O = fixed_r;
	assign AUTO_EXPOSURE_O = auto_out_r;
	assign FREE_O = free_r;
	assign CURRENT_SET_O = cur_r;
	assign RUNNING_O = in_run;
	assign SETUP_O = in_setup;
endmodule
`default_nettype wire

// *** verif/asq_seq_chk.sv ***
// port-level checks for the acquisition set sequencer
`timescale 1ns/1ps
`default_nettype none
module asq_seq_chk
	import asq_pkg::*;
#(
	parameter int DW = 32
) (
	input wire logic CLOCK_I,
	input wire logic RESETN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic PSLVERR_O,
	input wire logic STREAMING_I,
	input wire logic [DW-1:0] EXPOSURE_O,
	input wire logic [DW-1:0] FIXED_O,
	input wire logic AUTO_EXPOSURE_O,
	input wire logic [DW-1:0] FREE_O,
	input wire logic [ASQ_IDX_W-1:0] CURRENT_SET_O,
	input wire logic RUNNING_O,
	input wire logic SETUP_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RESETN_I);
	wire logic acc_wr = PSEL_I && PENABLE_I && PWRITE_I;
	wire logic wr_free = acc_wr && PADDR_I == OFF_FREE;
	wire logic wr_fixed = acc_wr && PADDR_I == OFF_FIXED;
	sequence s_wr_ok(logic [7:0] a);
		acc_wr && !PSLVERR_O && PADDR_I == a;
	endsequence
	// refused writes must not slip through, so accepted ones carry the data
	a_free_write: assert property (s_wr_ok(OFF_FREE) |=> FREE_O == $past(PWDATA_I[DW-1:0]))
		else $error("free feature did not take written value");
	a_free_only_apb: assert property ($changed(FREE_O) |-> $past(wr_free))
		else $error("free feature changed without a write");
	a_fixed_only_apb: assert property ($changed(FIXED_O) |-> $past(wr_fixed))
		else $error("fixed feature changed without a write");
	a_auto_forced: assert property (RUNNING_O && $past(RUNNING_O) |-> !AUTO_EXPOSURE_O)
		else $error("auto feature active while running");
	a_status_ro: assert property (acc_wr && PADDR_I == OFF_STATUS |-> PSLVERR_O)
		else $error("status write not refused");
	a_phase_excl: assert property (!(RUNNING_O && SETUP_O))
		else $error("run and setup at once");
	a_run_entry: assert property ($rose(RUNNING_O) |-> !$past(STREAMING_I) && !$past(SETUP_O))
		else $error("run started while streaming or in setup");
	a_expo_cause: assert property ($changed(EXPOSURE_O) |->
		$past(acc_wr) || $past(acc_wr, 2) || $past(RUNNING_O))
		else $error("exposure changed without cause");
	a_hop_cause: assert property ($changed(CURRENT_SET_O) |-> $past(acc_wr) ||
		$past(acc_wr, 2) || $past(STREAMING_I) || $past(STREAMING_I, 2))
		else $error("current set moved without cause");
endmodule
bind asq_seq asq_seq_chk #(.DW(DW)) chk_u (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I), .PSLVERR_O(PSLVERR_O), .STREAMING_I(STREAMING_I),
	.EXPOSURE_O(EXPOSURE_O), .FIXED_O(FIXED_O), .AUTO_EXPOSURE_O(AUTO_EXPOSURE_O),
	.FREE_O(FREE_O), .CURRENT_SET_O(CURRENT_SET_O), .RUNNING_O(RUNNING_O),
	.SETUP_O(SETUP_O));
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the acquisition set sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("MISMATCH %s exp %h got %h", nm, (e), (g)); \
	end \
end
module tb
	import asq_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic frame = 1'b0;
	logic streaming = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] lines = 4'h0;
	logic [31:0] rd;
	wire logic [31:0] prdata, exposure, gain, implied, fixed, free;
	wire logic pready, pslverr, auto_exp, running, setup;
	wire logic [2:0] cur;
	int err_count = 0;
	int compares = 0;
	always #10 clk = ~clk;
	asq_seq dut_u (.CLOCK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .FRAME_BEGIN_I(frame), .LINE_I(lines),
		.STREAMING_I(streaming), .EXPOSURE_O(exposure), .GAIN_O(gain), .IMPLIED_O(implied),
		.FIXED_O(fixed), .AUTO_EXPOSURE_O(auto_exp), .FREE_O(free), .CURRENT_SET_O(cur),
		.RUNNING_O(running), .SETUP_O(setup));
	task automatic print_verdict();
		if (err_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ends at the falling edge so the write's effect is visible to the caller
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge clk);
			n++;
		end
		if (n >= 16) begin
			err_count++;
			print_verdict();
		end
		rd = prdata;
		`CHK("pslverr", e, pslverr)
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d, e);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
		apb(1'b0, a, 32'h0, 1'b0);
		`CHK("read", x, rd & m)
	endtask
	task automatic t_reset();
		rdchk(OFF_STATUS, 32'h0, 32'hffff_ffff);
		`CHK("cur", 3'h0, cur)
		wr(8'h3c, 32'h1, 1'b1);
		wr(OFF_STATUS, 32'h1, 1'b1);
	endtask
	task automatic t_setup();
		wr(OFF_AUTO, 32'h1, 1'b0);
		wr(OFF_FSEL, 32'h0, 1'b0);
		wr(OFF_FEN, 32'h1, 1'b0);
		wr(OFF_CTRL, 32'h1, 1'b0);
		`CHK("setup", 1'b1, setup)
		wr(OFF_FIXED, 32'h5, 1'b1);
		wr(OFF_CTRL, 32'h0, 1'b0);
		wr(OFF_FIXED, 32'h3, 1'b0);
		`CHK("fixed", 32'h3, fixed)
		wr(OFF_CTRL, 32'h1, 1'b0);
		wr(OFF_AUTO, 32'h1, 1'b0);
		// the index field is three bits, so eight wraps onto set zero
		wr(OFF_SETSEL, 32'h8, 1'b0);
		rdchk(OFF_SETSEL, 32'h0, 32'hffff_ffff);
		for (int i = 0; i < 2; i++) begin
			wr(OFF_SETSEL, 32'(i), 1'b0);
			wr(OFF_GAIN, 32'(i + 1), 1'b0);
			wr(OFF_EXPOSURE, 32'(32'h40 >> i), 1'b0);
			wr(OFF_IMPLIED, 32'(7 + 2 * i), 1'b0);
			wr(OFF_PATH, 32'((1 - i) << PATH_NEXT_LSB), 1'b0);
			wr(OFF_CMD, 32'h1, 1'b0);
		end
		wr(OFF_BRANCH, 32'h1, 1'b1);
		wr(OFF_FIRST, 32'h0, 1'b0);
		rdchk(OFF_STATUS, 32'h0000_0300, 32'h0000_ff00);
		wr(OFF_CTRL, 32'h0, 1'b0);
		rdchk(OFF_STATUS, 32'h0000_0307, 32'h0007_ffff);
	endtask
	task automatic t_run();
		@(posedge clk);
		streaming <= 1'b1;
		wr(OFF_CTRL, 32'h2, 1'b1);
		@(posedge clk);
		streaming <= 1'b0;
		wr(OFF_CTRL, 32'h2, 1'b0);
		@(negedge clk);
		`CHK("expo", 32'h40, exposure)
		`CHK("impl", 32'h7, implied)
		`CHK("gain", 32'h2, gain)
		`CHK("auto", 1'b0, auto_exp)
		`CHK("cur", 3'h0, cur)
		wr(OFF_EXPOSURE, 32'h1, 1'b1);
		wr(OFF_IMPLIED, 32'h1, 1'b1);
		wr(OFF_FIXED, 32'h1, 1'b1);
		wr(OFF_FREE, 32'h0000_abcd, 1'b0);
		`CHK("free", 32'h0000_abcd, free)
		@(posedge clk);
		streaming <= 1'b1;
		// three hops so the run ends on the second set
		for (int k = 1; k < 5; k++) begin
			@(posedge clk);
			frame <= 1'b1;
			@(posedge clk);
			frame <= 1'b0;
			streaming <= (k < 3);
			@(negedge clk);
			`CHK("expo", (k % 2 == 1) ? 32'h20 : 32'h40, exposure)
			@(negedge clk);
			`CHK("cur", 3'((k % 2 == 1) ? 1 : 0), cur)
			`CHK("impl", (k % 2 == 1) ? 32'h9 : 32'h7, implied)
			if (k == 3) begin
				k = 5;
			end
		end
		@(posedge clk);
		frame <= 1'b1;
		@(posedge clk);
		frame <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK("cur", 3'h1, cur)
		wr(OFF_CTRL, 32'h0, 1'b0);
		@(negedge clk);
		`CHK("expo", 32'h20, exposure)
		`CHK("auto", 1'b1, auto_exp)
	endtask
	task automatic t_recall();
		wr(OFF_SETSEL, 32'h0, 1'b0);
		wr(OFF_CMD, 32'h2, 1'b0);
		@(negedge clk);
		`CHK("expo", 32'h40, exposure)
		`CHK("cur", 3'h0, cur)
		wr(OFF_FIXED, 32'h5, 1'b0);
		rdchk(OFF_STATUS, 32'h0, 32'h0000_ff00);
		wr(OFF_CMD, 32'h2, 1'b1);
		wr(OFF_CMD, 32'h1, 1'b1);
		wr(OFF_FIXED, 32'h3, 1'b0);
		rdchk(OFF_STATUS, 32'h0000_0300, 32'h0000_ff00);
		wr(OFF_CMD, 32'h4, 1'b0);
		rdchk(OFF_STATUS, 32'h0, 32'h0000_ff01);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_setup();
		t_run();
		t_recall();
		print_verdict();
	end
endmodule
`default_nettype wire
